// [dv/tb.sv]
// Purpose: Self-checking bench for the watchdog timeout control block
// Assumes: Crystal rate set equal to the bus clock, so one tick per cycle
// Notes:   Code 0 gives a 512-cycle period, code 1 a 1024-cycle period
`default_nettype none

module tb;
  import wdt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic         pclk;
  logic         presetn;
  logic         supply_monitor;
  wdt_apb_req_t req;
  logic         pready;
  logic [31:0]  prdata;
  logic         pslverr;
  logic         wdt_rst_req;
  logic         wdt_irq_hi;
  logic         wdt_hi_prio;
  logic         irq;
  int           error_cnt;
  int           total_checks;
  int           n;
  logic [31:0]  r;
  logic         e;

  // Tick every cycle keeps timeouts short enough to simulate
  wdt_timeout_ctrl #(.CLK_HZ(100_000_000), .XTAL_HZ(100_000_000)) DUT (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .supply_monitor(supply_monitor), .wdt_rst_req(wdt_rst_req),
    .wdt_irq_hi(wdt_irq_hi), .wdt_hi_prio(wdt_hi_prio), .irq(irq));

  // ==========================================================================
  // Clock, reset and watchdog
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Tests take under 10k cycles; this cuts a hang well past that
  initial begin
    #500us;
    error_cnt++;
    conclude();
  end

  // ==========================================================================
  // Bus and compare tasks
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int v);
    total_checks++;
    if (v < lo || v > hi) begin
      error_cnt++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", nm, lo, hi, v);
    end
  endtask

  // One APB transfer; an idle edge after release avoids a same-step reassignment
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    req <= '0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, r);
  endtask

  // Unlock, then the real control write as the very next access
  task automatic ctrl_wr(input logic [7:0] d);
    apb(1'b1, WDT_OFS_CTRL, 32'h1);
    apb(1'b1, WDT_OFS_CTRL, {24'h0, d});
  endtask

  // Cycles until the reset request or the watchdog interrupt is seen
  task automatic wait_ev(input bit rst, input int lim);
    n = 0;
    while (n < lim && (rst ? wdt_rst_req : wdt_irq_hi) !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic hw_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset_lock();
    rd_chk("ctrl reset", WDT_OFS_CTRL, 32'h10);
    chk("hi prio", 32'h1, wdt_hi_prio);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped slverr", 32'h1, e);
    apb(1'b1, WDT_OFS_CTRL, 32'h1a);
    apb(1'b1, WDT_OFS_CTRL, 32'h1);
    rd_chk("ctrl unlocked", WDT_OFS_CTRL, 32'h11);
    apb(1'b1, WDT_OFS_CTRL, 32'h1a);
    rd_chk("ctrl relocked", WDT_OFS_CTRL, 32'h10);
  endtask

  // Refreshing inside each period never lets the timeout fire
  task automatic t_refresh();
    ctrl_wr(8'h0a);
    repeat (3) begin
      repeat (400) @(posedge pclk);
      chk("irq during refresh", 32'h0, wdt_irq_hi);
      ctrl_wr(8'h0a);
    end
    ctrl_wr(8'h08);
    repeat (600) @(posedge pclk);
    chk("irq disabled", 32'h0, wdt_irq_hi);
  endtask

  task automatic t_irq();
    apb(1'b1, WDT_OFS_MASK, 32'h1);
    ctrl_wr(8'h1a);
    wait_ev(1'b0, 1100);
    chk_rng("code1 period", 1010, 1030, n);
    chk("irq out", 32'h1, irq);
    rd_chk("ctrl flag", WDT_OFS_CTRL, 32'h1e);
    apb(1'b1, WDT_OFS_STATUS, 32'h3);
    chk("irq cleared", 32'h0, irq);
    n = 0;
    while (n < 1100 && irq !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
    chk_rng("interval", 1000, 1030, n);
    ctrl_wr(8'h18);
    chk("irq hi clr", 32'h0, wdt_irq_hi);
  endtask

  task automatic t_rst();
    apb(1'b1, WDT_OFS_STATUS, 32'h3);
    ctrl_wr(8'h02);
    wait_ev(1'b1, 600);
    chk_rng("code0 period", 500, 520, n);
    rd_chk("ctrl after wd rst", WDT_OFS_CTRL, 32'h04);
    rd_chk("status", WDT_OFS_STATUS, 32'h3);
    hw_reset();
    rd_chk("ctrl after hw rst", WDT_OFS_CTRL, 32'h10);
  endtask

  // Code 1000 resets at once with either response select; reserved codes are never written
  task automatic t_imm();
    logic [7:0] v;
    for (int c = 0; c < 2; c++) begin
      v = (c == 0) ? 8'h82 : 8'h8a;
      ctrl_wr(v);
      wait_ev(1'b1, 8);
      chk_rng("immediate", 0, 4, n);
    end
  endtask

  task automatic t_psm();
    ctrl_wr(8'h02);
    supply_monitor <= 1'b1;
    @(posedge pclk);
    supply_monitor <= 1'b0;
    rd_chk("ctrl after psm", WDT_OFS_CTRL, 32'h00);
    wait_ev(1'b1, 600);
    chk_rng("no rst after psm", 600, 600, n);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    supply_monitor = 1'b0;
    req = '0;
    error_cnt = 0;
    total_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_lock();
    t_refresh();
    t_irq();
    t_rst();
    t_imm();
    t_psm();
    conclude();
  end
endmodule // tb

`default_nettype wire

// [hw/wdt_timeout_ctrl.sv]
// Purpose: Watchdog timeout control with APB register access
// Assumes: Core asserts presetn for hardware reset; watchdog reset is requested on wdt_rst_req
// Notes:   Watchdog reset does not reset this block, so the timeout flag survives it
`default_nettype none

// Behaviour
// R01 - Codes 0101, 0110, 0111 give 500, 1000 and 2000 ms periods and code 1000 resets at once.
// R02 - Software must not program a code above 1000 since those codes are reserved.
// R03 - With response select set, expiry raises the watchdog interrupt instead of a reset.
// R04 - The watchdog interrupt is not blocked by the global interrupt enable.
// R05 - The watchdog interrupt is always high priority and software cannot change that.
// R06 - With response select set, the watchdog acts as an interval timer interrupting each period.
// R07 - Every timeout sets the timeout status flag.
// R08 - The timeout flag clears on a software write of 0 or on a hardware reset.
// R09 - A watchdog reset leaves the timeout flag set for software to inspect.
// R10 - Setting the enable bit enables the watchdog and clears its counter.
// R11 - Software must set enable again within each period or a reset or interrupt follows.
// R12 - Enable clears on a 0 write, a watchdog reset, a hardware reset or a supply-monitor event.
// R13 - The period is 2^code times 512 crystal ticks at 32.768 kHz.
// R14 - A control write is accepted only as the access right after setting the unlock bit.
// R15 - The counter advances on a crystal-rate tick independent of the core clock setting.
module wdt_timeout_ctrl #(
  parameter int unsigned CLK_HZ  = wdt_pkg::WDT_CLK_HZ,
  parameter int unsigned XTAL_HZ = wdt_pkg::WDT_XTAL_HZ
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire wdt_pkg::wdt_apb_req_t apb_req,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  input  wire logic                 supply_monitor,
  output logic                      wdt_rst_req,
  output logic                      wdt_irq_hi,
  output logic                      wdt_hi_prio,
  output logic                      irq
);
  import wdt_pkg::*;

  // ==========================================================================
  // Period limit in crystal ticks for a valid code
  function automatic logic [WDT_CNT_W-1:0] period_ticks(input logic [3:0] code);
    period_ticks = WDT_CNT_W'(WDT_BASE_TICKS) << code[2:0]; // [R13] [R01]
  endfunction

  function automatic logic [31:0] ctrl_word(input wdt_ctrl_t c, input logic u);
    ctrl_word = {24'h0, c.code, c.resp_sel, c.flag, c.enable, u};
  endfunction

  wdt_state_t st_q;
  wdt_state_t st_d;
  logic       tick;
  logic       setup;
  logic       acc_wr;
  logic       wr_ctrl;
  logic       timeout;
  logic       immed;
  logic       mapped;

  // ==========================================================================
  // Crystal tick keeps the period fixed whatever the core clock setting
  wdt_xtal_tick #(
    .CLK_HZ  (CLK_HZ),
    .XTAL_HZ (XTAL_HZ)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)                                              // [R15]
  );

  // ==========================================================================
  // APB decode; zero wait states, read data captured in setup
  assign setup   = apb_req.psel && !apb_req.penable;
  assign acc_wr  = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign wr_ctrl = acc_wr && (apb_req.paddr == WDT_OFS_CTRL);
  assign mapped  = apb_req.paddr inside {WDT_OFS_CTRL, WDT_OFS_STATUS,
                                         WDT_OFS_MASK, WDT_OFS_COUNT};

  // Expiry on the last tick of the period; reserved codes act as the immediate reset
  assign timeout = st_q.ctrl.enable && tick && (st_q.ctrl.code < WDT_CODE_IMM) &&
                   (st_q.count == period_ticks(st_q.ctrl.code) - 1'b1); // [R13] [R11]
  assign immed   = st_q.ctrl.enable && (st_q.ctrl.code >= WDT_CODE_IMM); // [R01]

  // ==========================================================================
  // Next state
  always_comb begin
    st_d         = st_q;
    st_d.rst_req = 1'b0;

    // Count crystal ticks while enabled
    if (st_q.ctrl.enable && tick) begin
      st_d.count = st_q.count + 1'b1;                              // [R15]
    end

    // Unlock lasts for exactly one following access
    if (apb_req.psel && apb_req.penable) begin
      st_d.unlock = 1'b0;                                          // [R14]
    end

    if (wr_ctrl) begin
      if (st_q.unlock) begin
        st_d.ctrl.code     = apb_req.pwdata[WDT_POS_CODE +: 4];    // [R14]
        st_d.ctrl.resp_sel = apb_req.pwdata[WDT_POS_RESP];
        st_d.ctrl.enable   = apb_req.pwdata[WDT_POS_EN];           // [R12]
        if (!apb_req.pwdata[WDT_POS_FLAG]) begin
          st_d.ctrl.flag = 1'b0;                                   // [R08]
        end
        if (apb_req.pwdata[WDT_POS_EN]) begin
          st_d.count = '0;                                         // [R10]
        end
      end else if (apb_req.pwdata[WDT_POS_UNLOCK]) begin
        st_d.unlock = 1'b1;                                        // [R14]
      end
    end

    // Other registers: W1C event status and its mask
    if (acc_wr && apb_req.paddr == WDT_OFS_STATUS) begin
      st_d.evt_status = st_q.evt_status & ~apb_req.pwdata[1:0];
    end
    if (acc_wr && apb_req.paddr == WDT_OFS_MASK) begin
      st_d.evt_mask = apb_req.pwdata[1:0];
    end

    // Expiry: sets the flag, then interrupt or reset; set beats any clear
    if (timeout || immed) begin
      st_d.ctrl.flag                  = 1'b1;                      // [R07] [R09]
      st_d.count                      = '0;
      st_d.evt_status[WDT_EVT_TMO]    = 1'b1;
      if (st_q.ctrl.resp_sel && !immed) begin
        st_d.wd_irq = 1'b1;                                        // [R03] [R06]
      end else begin
        st_d.rst_req                 = 1'b1;                       // [R11]
        st_d.ctrl.enable             = 1'b0;                       // [R12]
        st_d.evt_status[WDT_EVT_RST] = 1'b1;
      end
    end

    // Handler acknowledges by clearing the flag
    if (!st_d.ctrl.flag) begin
      st_d.wd_irq = 1'b0;
    end

    // Supply monitor drops the enable
    if (supply_monitor) begin
      st_d.ctrl.enable = 1'b0;                                     // [R12]
    end

    // Read data and error captured in the setup cycle
    if (setup) begin
      st_d.slverr = !mapped;
      unique case (apb_req.paddr)
        WDT_OFS_CTRL:   st_d.rdata = ctrl_word(st_q.ctrl, st_q.unlock);
        WDT_OFS_STATUS: st_d.rdata = {30'h0, st_q.evt_status};
        WDT_OFS_MASK:   st_d.rdata = {30'h0, st_q.evt_mask};
        WDT_OFS_COUNT:  st_d.rdata = {{(32 - WDT_CNT_W){1'b0}}, st_q.count};
        default:        st_d.rdata = 32'h0;
      endcase
    end
  end

  // ==========================================================================
  // State register; hardware reset clears flag and enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q            <= '0;
      st_q.ctrl       <= wdt_ctrl_t'(WDT_CTRL_RST[7:1]);            // [R08] [R12]
      st_q.evt_status <= WDT_EVT_RST_V;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs; watchdog interrupt bypasses the global enable, fixed high priority
  assign pready      = 1'b1;
  assign prdata      = st_q.rdata;
  assign pslverr     = st_q.slverr;
  assign wdt_rst_req = st_q.rst_req;
  assign wdt_irq_hi  = st_q.wd_irq;                                // [R04]
  assign wdt_hi_prio = 1'b1;                                       // [R05]
  assign irq         = |(st_q.evt_status & st_q.evt_mask);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  flag_set_a: assert property (timeout |=> st_q.ctrl.flag)         // [R07]
    else $error("timeout did not set the flag");

  reset_on_expire_a: assert property (timeout && !st_q.ctrl.resp_sel |=>
                                       wdt_rst_req && !st_q.ctrl.enable) // [R11]
    else $error("expiry without response select gave no reset");

  irq_on_expire_a: assert property (timeout && st_q.ctrl.resp_sel |=>
                                     wdt_irq_hi && !wdt_rst_req)   // [R03]
    else $error("expiry with response select gave no interrupt");

  psm_clears_en_a: assert property (supply_monitor |=> !st_q.ctrl.enable) // [R12]
    else $error("supply monitor did not clear enable");

  immediate_reset_a: assert property (st_q.ctrl.enable &&
                                       st_q.ctrl.code == WDT_CODE_IMM |=> wdt_rst_req) // [R01]
    else $error("code 1000 did not reset at once");

  locked_write_a: assert property (wr_ctrl && !st_q.unlock |=>
                                    $stable(st_q.ctrl.code) && $stable(st_q.ctrl.resp_sel)) // [R14]
    else $error("control changed without unlock");

  restart_count_a: assert property (wr_ctrl && st_q.unlock &&
                                     apb_req.pwdata[WDT_POS_EN] && !timeout |=>
                                     st_q.count == '0)             // [R10]
    else $error("enable write did not clear counter");

  flag_kept_a: assert property (wdt_rst_req |-> st_q.ctrl.flag ##1 st_q.ctrl.flag) // [R09]
    else $error("watchdog reset lost the flag");

  period_limit_a: assert property (timeout |-> st_q.count ==
                                    period_ticks(st_q.ctrl.code) - 1'b1 &&
                                    $past(st_q.ctrl.enable))      // [R13]
    else $error("timeout at wrong count");

endmodule // wdt_timeout_ctrl

`default_nettype wire

// [hw/wdt_xtal_tick.sv]
// Purpose: Crystal-rate tick from the bus clock by a phase accumulator
// Assumes: CLK_HZ greater than or equal to XTAL_HZ
// Notes:   Average tick rate is exact; single intervals jitter by one cycle
`default_nettype none

module wdt_xtal_tick #(
  parameter int unsigned CLK_HZ  = 100_000_000,
  parameter int unsigned XTAL_HZ = 32768
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  import wdt_pkg::*;

  wdt_tick_state_t st_q;
  wdt_tick_state_t st_d;

  // ==========================================================================
  // Accumulate the crystal rate; wrap at the clock rate and fire a tick
  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (st_q.acc + XTAL_HZ >= CLK_HZ) begin
      st_d.acc  = st_q.acc + XTAL_HZ - CLK_HZ;
      st_d.tick = 1'b1;
    end else begin
      st_d.acc = st_q.acc + XTAL_HZ;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

endmodule // wdt_xtal_tick

`default_nettype wire

// [include/wdt_pkg.sv]
// Purpose: Shared constants and carrier types for the watchdog timeout control block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Control register layout mirrors the 8-bit watchdog control byte
`default_nettype none

package wdt_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] WDT_OFS_CTRL   = 8'h00;
  localparam logic [7:0] WDT_OFS_STATUS = 8'h04;
  localparam logic [7:0] WDT_OFS_MASK   = 8'h08;
  localparam logic [7:0] WDT_OFS_COUNT  = 8'h0c;

  // ==========================================================================
  // Control register field positions and reset value
  localparam int         WDT_POS_CODE   = 4;
  localparam int         WDT_POS_RESP   = 3;
  localparam int         WDT_POS_FLAG   = 2;
  localparam int         WDT_POS_EN     = 1;
  localparam int         WDT_POS_UNLOCK = 0;
  localparam logic [7:0] WDT_CTRL_RST   = 8'h10;

  // Event status bits (timeout seen, reset requested)
  localparam int         WDT_EVT_TMO    = 0;
  localparam int         WDT_EVT_RST    = 1;
  localparam logic [1:0] WDT_EVT_RST_V  = 2'h0;

  // ==========================================================================
  // Timing: period is 2^code times the base count of crystal ticks
  localparam int          WDT_XTAL_HZ    = 32768;
  localparam int          WDT_CLK_HZ     = 100_000_000;
  localparam int          WDT_BASE_TICKS = 512;
  localparam logic [3:0]  WDT_CODE_IMM   = 4'h8;
  localparam int          WDT_CNT_W      = 17;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } wdt_apb_req_t;

  typedef struct packed {
    logic [3:0] code;
    logic       resp_sel;
    logic       flag;
    logic       enable;
  } wdt_ctrl_t;

  typedef struct packed {
    wdt_ctrl_t              ctrl;
    logic                   unlock;
    logic [WDT_CNT_W-1:0]   count;
    logic                   wd_irq;
    logic [1:0]             evt_status;
    logic [1:0]             evt_mask;
    logic                   rst_req;
    logic [31:0]            rdata;
    logic                   slverr;
  } wdt_state_t;

  typedef struct packed {
    logic [31:0] acc;
    logic        tick;
  } wdt_tick_state_t;

endpackage : wdt_pkg

`default_nettype wire
